// ### adc_seq_pkg.sv
// Shared constants for the diagnostic converter sequencer
package adc_seq_pkg;

    // ------------------------------------------------------------
    // Clocking and timing
    // ------------------------------------------------------------
    localparam int MCLK_HZ         = 25_000_000;
    localparam int OSC_HZ          = 1_228_800;    // Nominal oscillator rate
    localparam int ADC_DIV         = 16;           // ADC clock divider
    localparam int ADC_CLK_HZ      = OSC_HZ / ADC_DIV;
    localparam int MIN_CONV_TICKS  = 20;
    localparam int PWR_WAIT_US     = 210;
    // Least time; 25 cycles per microsecond is exact, no rounding
    localparam int PWR_WAIT_CYCLES =
        (PWR_WAIT_US * (MCLK_HZ / 1_000_000) + 0);

    // Conversion rates in Hz and their lengths in ADC clock ticks
    localparam int RATE_640_HZ  = 640;
    localparam int RATE_1280_HZ = 1280;
    localparam int RATE_2560_HZ = 2560;
    localparam int RATE_3840_HZ = 3840;
    localparam logic [6:0] TICKS_640  = 7'(ADC_CLK_HZ / RATE_640_HZ);
    localparam logic [6:0] TICKS_1280 = 7'(ADC_CLK_HZ / RATE_1280_HZ);
    localparam logic [6:0] TICKS_2560 = 7'(ADC_CLK_HZ / RATE_2560_HZ);
    localparam logic [6:0] TICKS_3840 = 7'(ADC_CLK_HZ / RATE_3840_HZ);

    // ------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // ------------------------------------------------------------
    localparam logic [7:0] IDX_CONFIG    = 8'h20;
    localparam logic [7:0] IDX_TRIGGER   = 8'h21;
    localparam logic [7:0] IDX_STATUS    = 8'h22;
    localparam logic [7:0] IDX_EXT0      = 8'h24;
    localparam logic [7:0] IDX_EXT1      = 8'h25;
    localparam logic [7:0] IDX_TEMP      = 8'h26;
    localparam logic [7:0] IDX_OFFSET    = 8'h28;

    // Config register fields
    localparam int CFG_FIRST_LSB = 0;
    localparam int CFG_LAST_LSB  = 4;
    localparam int CFG_SINGLE    = 8;
    localparam int CFG_SPAN      = 9;
    localparam int CFG_RATE_LSB  = 10;
    localparam int CFG_BUF_PD    = 12;
    localparam int CFG_OFS_SKIP  = 13;
    localparam int CFG_IN1_EN    = 14;
    localparam int CFG_WIDTH     = 15;
    localparam logic [CFG_WIDTH-1:0] CFG_RESET = 15'h5_080;

    // ------------------------------------------------------------
    // Slots and codes
    // ------------------------------------------------------------
    localparam logic [3:0]  SLOT_OFFSET   = 4'h0;
    localparam logic [3:0]  SLOT_EXT0     = 4'h1;
    localparam logic [3:0]  SLOT_EXT1     = 4'h2;
    localparam logic [3:0]  SLOT_TEMP     = 4'h3;
    localparam logic [3:0]  SLOT_DAC_NODE = 4'h8;
    localparam logic [11:0] MID_CODE      = 12'h7FF;
    localparam logic [11:0] ZERO_CODE     = 12'h000;
    localparam logic [11:0] FULL_CODE     = 12'hFFF;

endpackage

// ### slot_timer.sv
// Conversion slot timer: ADC clock divider and tick counter
`timescale 1ns/1ps
module slot_timer
    import adc_seq_pkg::*;
#(
    parameter int DIV = ADC_DIV
) (
    input  wire logic       mclk,
    input  wire logic       rst_n,
    input  wire logic       ce,
    input  wire logic       start,
    input  wire logic [6:0] ticks,
    output logic            done
);

    logic [3:0] divCnt_reg;
    logic [6:0] tickCnt_reg;
    logic       running_reg;
    logic       adcTick;

    // ADC clock edge once every DIV system cycles
    assign adcTick = (divCnt_reg == 4'(DIV - 1));

    // ------------------------------------------------------------
    // Divider, restarted with each slot so slot length is exact
    // ------------------------------------------------------------
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            divCnt_reg <= 4'h0;
        end else if (ce) begin
            if (start || adcTick) begin
                divCnt_reg <= 4'h0;
            end else begin
                divCnt_reg <= divCnt_reg + 4'h1;
            end
        end
    end

    // Tick counter; done pulses on the last ADC tick of the slot
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            tickCnt_reg <= 7'h00;
            running_reg <= 1'b0;
        end else if (ce) begin
            if (start) begin
                tickCnt_reg <= ticks;
                running_reg <= 1'b1;
            end else if (running_reg && adcTick) begin
                tickCnt_reg <= tickCnt_reg - 7'h01;
                if (tickCnt_reg == 7'h01) begin
                    running_reg <= 1'b0;
                end
            end
        end
    end

    assign done = ce && running_reg && adcTick && (tickCnt_reg == 7'h01);

endmodule

// ### adc_channel_sequencer.sv
// Channel sequencer, timing and result registers for the diagnostic ADC
//
// What this block does
// - Sixteen ordered slots; first and last index fields bound the conversions.
// - Single-pass mode converts first to last once per trigger, then idles.
// - Continuous mode loops first to last while conversion stays enabled.
// - Fixed order: offset, two inputs, temperature, five diagnostics, ground.
// - Non-input slots run at 2560 Hz, one reference span; slot 8 twice.
// - Equal indices convert one slot; first below last converts every slot between them.
// - After reset first index is 0 and last index is 8.
// - Disabled second input reads zero but still takes its slot time.
// - First index above last acts as if last equals first.
// - Continuous: writing 1 starts; writing 0 stops after the current slot.
// - Single-pass: writing 1 starts; trigger clears itself at sequence end.
// - Each conversion lasts at least 20 ticks of oscillator divided by 16.
// - Span select 0 gives twice reference, 1 gives one reference.
// - Rate field picks 640, 1280, 2560 or 3840 Hz for inputs.
// - Busy flag high while a sequence runs; trigger bit also shows idle.
// - Results hold the latest value; reads never stall conversions.
// - Offset slot stores 7FFh minus raw as two's complement at 28h.
// - Offset is subtracted from results unless offset skip is set.
// - Input results stored unsigned at 24h and 25h.
// - Input codes run 000 to FFF with 800 at mid-scale.
// - Temperature result is written at 26h when its slot finishes.
// - A trigger during the 210 us buffer wait is held off until it ends.
// - Single-pass select resets to continuous; 1 selects single-pass.
//
// Added by the designer: the APB interface to the registers.
`timescale 1ns/1ps
module adc_channel_sequencer
    import adc_seq_pkg::*;
#(
    parameter int PWR_WAIT = PWR_WAIT_CYCLES
) (
    input  wire logic        mclk,
    input  wire logic        rst_n,
    input  wire logic        ce,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    // Converter core
    input  wire logic [11:0] sampleData,
    output logic [3:0]       convSlot,
    output logic             convActive,
    output logic             convSpanDouble,
    output logic             bufferPowerDown
);

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_POWER_WAIT,
        ST_CONVERT
    } seq_state_e;

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    seq_state_e             state_reg;
    logic [CFG_WIDTH-1:0]   config_reg;
    logic                   trigger_reg;
    logic [3:0]             slot_reg;
    logic [11:0]            ext0Result_reg;
    logic [11:0]            ext1Result_reg;
    logic [11:0]            tempResult_reg;
    logic [11:0]            offsetValue_reg;
    logic [31:0]            prdata_reg;
    logic                   addrBad_reg;
    logic [12:0]            pwrCnt_reg;
    logic                   slotStart_reg;
    logic                   slotDone;
    logic                   pwrReady;
    logic [3:0]             firstSlot;
    logic [3:0]             lastSlot;
    logic [3:0]             effLast;
    logic [1:0]             rateSel;
    logic [6:0]             slotTicks;
    logic [11:0]            corrected;
    logic [12:0]            diff;
    logic [7:0]             regIndex;
    logic                   wrEn;
    logic                   setupPhase;
    logic                   trigWrite;
    logic                   seqEnd;

    // ------------------------------------------------------------
    // Configuration fields
    // ------------------------------------------------------------
    assign firstSlot = config_reg[CFG_FIRST_LSB +: 4];
    assign lastSlot  = config_reg[CFG_LAST_LSB +: 4];
    // A first index above the last collapses to one slot
    assign effLast   = (firstSlot > lastSlot) ? firstSlot : lastSlot;
    assign rateSel   = config_reg[CFG_RATE_LSB +: 2];

    // ------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------
    // Word index; the low two address bits select no byte lane
    assign regIndex   = paddr[9:2];
    assign setupPhase = psel && !penable;
    assign wrEn       = psel && penable && pwrite && !addrBad_reg;
    assign trigWrite  = wrEn && (regIndex == IDX_TRIGGER);
    // Zero wait states: reads come from a flop loaded in setup
    assign pready     = 1'b1;
    assign prdata     = prdata_reg;
    assign pslverr    = psel && penable && addrBad_reg;

    // Read data and address check captured during the setup cycle
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            prdata_reg  <= 32'h0000_0000;
            addrBad_reg <= 1'b0;
        end else if (ce && setupPhase) begin
            addrBad_reg <= 1'b0;
            prdata_reg  <= 32'h0000_0000;
            unique case (regIndex)
                IDX_CONFIG:  prdata_reg <= {17'h0_0000, config_reg};
                IDX_TRIGGER: prdata_reg <= {31'h0000_0000, trigger_reg};
                IDX_STATUS:  prdata_reg <= {31'h0000_0000, convActive};
                IDX_EXT0:    prdata_reg <= {20'h0_0000, ext0Result_reg};
                IDX_EXT1:    prdata_reg <= {20'h0_0000, ext1Result_reg};
                IDX_TEMP:    prdata_reg <= {20'h0_0000, tempResult_reg};
                IDX_OFFSET:  prdata_reg <= {20'h0_0000, offsetValue_reg};
                default:     addrBad_reg <= 1'b1;
            endcase
            // Upper address bits set would alias a register, so refuse them
            if (paddr[11:10] != 2'b00) begin
                addrBad_reg <= 1'b1;
                prdata_reg  <= 32'h0000_0000;
            end
        end
    end

    // ------------------------------------------------------------
    // Configuration register
    // ------------------------------------------------------------
    // Reset gives first 0, last 8, continuous mode, buffer powered down
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            config_reg <= CFG_RESET;
        end else if (ce && wrEn && regIndex == IDX_CONFIG) begin
            // Writes mid-sequence are taken; software should avoid them
            config_reg <= pwdata[CFG_WIDTH-1:0];
        end
    end

    // ------------------------------------------------------------
    // Trigger bit
    // ------------------------------------------------------------
    // Sequence ends on the last slot in single-pass mode
    assign seqEnd = slotDone && (slot_reg == effLast) && config_reg[CFG_SINGLE];

    // A software write in the self-clear cycle wins so no start is lost
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            trigger_reg <= 1'b0;
        end else if (ce) begin
            if (trigWrite) begin
                trigger_reg <= pwdata[0];
            end else if (seqEnd) begin
                trigger_reg <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Buffer power-up timer
    // ------------------------------------------------------------
    // Restarts whenever the buffer is powered down
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            pwrCnt_reg <= 13'h0000;
        end else if (ce) begin
            if (config_reg[CFG_BUF_PD]) begin
                pwrCnt_reg <= 13'h0000;
            end else if (!pwrReady) begin
                pwrCnt_reg <= pwrCnt_reg + 13'h0001;
            end
        end
    end

    assign pwrReady = (pwrCnt_reg >= 13'(PWR_WAIT));
    assign bufferPowerDown = config_reg[CFG_BUF_PD];

    // ------------------------------------------------------------
    // Sequencer state machine
    // ------------------------------------------------------------
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg     <= ST_IDLE;
            slot_reg      <= 4'h0;
            slotStart_reg <= 1'b0;
        end else if (ce) begin
            slotStart_reg <= 1'b0;
            unique case (state_reg)
                ST_IDLE: begin
                    if (trigger_reg) begin
                        state_reg <= ST_POWER_WAIT;
                    end
                end
                ST_POWER_WAIT: begin
                    // Early trigger is held here until the buffer settles
                    if (!trigger_reg) begin
                        state_reg <= ST_IDLE;
                    end else if (pwrReady) begin
                        state_reg     <= ST_CONVERT;
                        slot_reg      <= firstSlot;
                        slotStart_reg <= 1'b1;
                    end
                end
                ST_CONVERT: begin
                    if (slotDone) begin
                        if (slot_reg == effLast) begin
                            if (config_reg[CFG_SINGLE] || !trigger_reg) begin
                                state_reg <= ST_IDLE;
                            end else begin
                                slot_reg      <= firstSlot;
                                slotStart_reg <= 1'b1;
                            end
                        end else if (!config_reg[CFG_SINGLE] && !trigger_reg) begin
                            // Stop only once the running slot is done
                            state_reg <= ST_IDLE;
                        end else begin
                            slot_reg      <= slot_reg + 4'h1;
                            slotStart_reg <= 1'b1;
                        end
                    end
                end
            endcase
        end
    end

    assign convActive = (state_reg != ST_IDLE);
    assign convSlot   = slot_reg;

    // ------------------------------------------------------------
    // Per-slot rate and span
    // ------------------------------------------------------------
    // Inputs take the programmed rate, all other slots the fixed one
    always_comb begin
        slotTicks = TICKS_2560;
        if (slot_reg == SLOT_EXT0 || slot_reg == SLOT_EXT1) begin
            unique case (rateSel)
                2'd0: slotTicks = TICKS_640;
                2'd1: slotTicks = TICKS_1280;
                2'd2: slotTicks = TICKS_2560;
                2'd3: slotTicks = TICKS_3840;
            endcase
        end
    end

    // Span bit low means twice the reference for the inputs
    always_comb begin
        if (slot_reg == SLOT_EXT0 || slot_reg == SLOT_EXT1) begin
            convSpanDouble = !config_reg[CFG_SPAN];
        end else begin
            convSpanDouble = (slot_reg == SLOT_DAC_NODE);
        end
    end

    // Slot length: the fastest rate still gives 20 ADC ticks
    slot_timer #(
        .DIV (ADC_DIV)
    ) u_timer (
        .mclk  (mclk),
        .rst_n (rst_n),
        .ce    (ce),
        .start (slotStart_reg),
        .ticks (slotTicks),
        .done  (slotDone)
    );

    // ------------------------------------------------------------
    // Offset correction
    // ------------------------------------------------------------
    // Subtract the stored offset and clamp to the unsigned code range
    always_comb begin
        diff = {1'b0, sampleData} - {offsetValue_reg[11], offsetValue_reg};
        if (config_reg[CFG_OFS_SKIP]) begin
            corrected = sampleData;
        end else if (offsetValue_reg[11] && diff[12]) begin
            corrected = FULL_CODE;
        end else if (!offsetValue_reg[11] && diff[12]) begin
            corrected = ZERO_CODE;
        end else begin
            corrected = diff[11:0];
        end
    end

    // ------------------------------------------------------------
    // Result registers
    // ------------------------------------------------------------
    // Whole-word update on the slot's last cycle, never partial
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            offsetValue_reg <= ZERO_CODE;
        end else if (ce && slotDone && slot_reg == SLOT_OFFSET) begin
            offsetValue_reg <= MID_CODE - sampleData;
        end
    end

    // Input results are straight binary, 000 to FFF
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            ext0Result_reg <= ZERO_CODE;
            ext1Result_reg <= ZERO_CODE;
        end else if (ce && slotDone) begin
            if (slot_reg == SLOT_EXT0) begin
                ext0Result_reg <= corrected;
            end
            if (slot_reg == SLOT_EXT1) begin
                // Unused second input reads zero yet kept its slot time
                ext1Result_reg <= config_reg[CFG_IN1_EN] ? corrected
                                                         : ZERO_CODE;
            end
        end
    end

    // Temperature result
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            tempResult_reg <= ZERO_CODE;
        end else if (ce && slotDone && slot_reg == SLOT_TEMP) begin
            tempResult_reg <= corrected;
        end
    end

endmodule

// ### adc_channel_sequencer_chk.sv
// Port checker for the converter sequencer
`timescale 1ns/1ps
module adc_channel_sequencer_chk
    import adc_seq_pkg::*;
(
    input wire logic        mclk,
    input wire logic        rst_n,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pready,
    input wire logic [31:0] prdata,
    input wire logic        pslverr,
    input wire logic [3:0]  convSlot,
    input wire logic        convActive,
    input wire logic        convSpanDouble,
    input wire logic        bufferPowerDown
);
    // ----------------------------------------
    // Helpers and assertions
    // ----------------------------------------
    logic       acc;
    logic       mapped;
    logic [3:0] slotQ;
    logic [9:0] stretch;
    assign acc    = psel && penable;
    assign mapped = paddr[11:10] == 2'b00 && paddr[9:2] inside
        {IDX_CONFIG, IDX_TRIGGER, IDX_STATUS, IDX_EXT0, IDX_EXT1, IDX_TEMP, IDX_OFFSET};
    // Cycles on the current slot; returns to zero after reaching 3FFh
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            slotQ   <= 4'h0;
            stretch <= 10'h000;
        end else begin
            slotQ   <= convSlot;
            stretch <= (convActive && convSlot == slotQ && stretch != 10'h3FF) ?
                       stretch + 10'h001 : 10'h000;
        end
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    chk_ready_high: assert property (pready)
        else $error("pready low");
    chk_err_unmapped: assert property (acc && !mapped |-> pslverr && prdata == 32'h0000_0000)
        else $error("unmapped access not refused");
    chk_err_mapped: assert property (acc && mapped |-> !pslverr)
        else $error("mapped access refused");
    chk_read_hold: assert property (acc |=> $stable(prdata))
        else $error("read data moved after access");
    chk_span_dac: assert property (
        convActive && convSlot == SLOT_DAC_NODE |-> convSpanDouble)
        else $error("slot 8 span not doubled");
    chk_span_fixed: assert property (
        convActive && convSlot != SLOT_EXT0 && convSlot != SLOT_EXT1
        && convSlot != SLOT_DAC_NODE |-> !convSpanDouble)
        else $error("fixed slot span doubled");
    chk_bufpd_follow: assert property (
        acc && pwrite && mapped && paddr[9:2] == IDX_CONFIG
        |=> bufferPowerDown == $past(pwdata[CFG_BUF_PD]))
        else $error("buffer power down not following config");
    chk_busy_start: assert property (
        acc && pwrite && mapped && paddr[9:2] == IDX_TRIGGER && pwdata[0] && !convActive
        |-> ##[1:2] convActive)
        else $error("trigger did not start the sequencer");
    chk_slot_min: assert property ($fell(convActive) |-> stretch >= 10'd310)
        else $error("last slot cut short");
endmodule

bind adc_channel_sequencer adc_channel_sequencer_chk chk (
    .mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .convSlot(convSlot), .convActive(convActive),
    .convSpanDouble(convSpanDouble), .bufferPowerDown(bufferPowerDown));

// ### tb_adc_channel_sequencer.sv
// Self-checking bench for the converter sequencer
`timescale 1ns/1ps
module tb_adc_channel_sequencer
    import adc_seq_pkg::*;
;
    // ----------------------------------------
    // Stimulus, design and scenarios
    // ----------------------------------------
    localparam int PW = 20;    // Short buffer wait keeps the run brief
    logic        mclk = 1'b0;
    logic        rst_n = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [11:0] sampleData = 12'h000;
    logic        pready, pslverr, convActive, convSpanDouble, bufferPowerDown;
    logic [31:0] prdata, rd;
    logic [3:0]  convSlot;
    logic        err, span;
    int          nErrors = 0;
    int          checkCount = 0;
    int          cyc;
    logic [6:0]  tk [4] = '{TICKS_640, TICKS_1280, TICKS_2560, TICKS_3840};

    adc_channel_sequencer #(.PWR_WAIT(PW)) uut (
        .mclk(mclk), .rst_n(rst_n), .ce(1'b1), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
        .prdata(prdata), .pslverr(pslverr), .sampleData(sampleData),
        .convSlot(convSlot), .convActive(convActive),
        .convSpanDouble(convSpanDouble), .bufferPowerDown(bufferPowerDown));

    initial forever #20 mclk = ~mclk;

    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        checkCount++;
        if (got !== exp) begin
            nErrors++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask
    // Slot times are bench counts, so a window rather than one exact figure
    task automatic checkRange(input string name, input int lo, input int hi, input int got);
        checkCount++;
        if (got < lo || got > hi) begin
            nErrors++;
            $display("Error %s expected %0d to %0d seen %0d", name, lo, hi, got);
        end
    endtask
    // Zero wait states expected, but the wait on pready is kept anyway
    task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] d);
        @(posedge mclk);
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= {2'b00, idx, 2'b00};
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        @(posedge mclk);
        while (pready !== 1'b1) @(posedge mclk);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    function automatic logic [31:0] cfgw(input int first, last, single, sp, rate, skip, in1);
        return 32'(first | last << CFG_LAST_LSB | single << CFG_SINGLE | sp << CFG_SPAN
            | rate << CFG_RATE_LSB | skip << CFG_OFS_SKIP | in1 << CFG_IN1_EN);
    endfunction
    // One triggered pass, busy window timed at falling edges
    task automatic runOnce(input logic [31:0] cfg, input logic [11:0] smp);
        int n;
        apb(1'b1, IDX_CONFIG, cfg);
        sampleData <= smp;
        apb(1'b1, IDX_TRIGGER, 32'h0000_0001);
        n = 0;
        cyc = 0;
        while (convActive !== 1'b1 && n < 10) begin
            @(negedge mclk);
            n++;
        end
        while (convActive === 1'b1 && cyc < 5000) begin
            @(negedge mclk);
            cyc++;
            span = convSpanDouble;
        end
    endtask
    task automatic resetCheck();
        logic [31:0] keep;
        apb(1'b0, IDX_CONFIG, 32'h0000_0000);
        check("config", 32'(CFG_RESET), rd);
        check("first last mode", 32'h0000_0080, rd & 32'h0000_01FF);
        apb(1'b0, IDX_STATUS, 32'h0000_0000);
        check("busy", 32'h0000_0000, rd);
        apb(1'b0, 8'h23, 32'h0000_0000);
        check("unmapped err", 32'h0000_0001, 32'(err));
        apb(1'b0, IDX_TEMP, 32'h0000_0000);
        keep = rd;
        apb(1'b1, IDX_TEMP, 32'h0000_0FFF);
        apb(1'b0, IDX_TEMP, 32'h0000_0000);
        check("temp read only", keep, rd);
        // Buffer powers up here; the next trigger comes early on purpose
        apb(1'b1, IDX_CONFIG, cfgw(0, 0, 1, 0, 0, 0, 1));
    endtask
    task automatic offsetCal();
        runOnce(cfgw(0, 0, 1, 0, 0, 0, 1), 12'h7F0);
        checkRange("offset slot time", 474 + PW, 482 + PW, cyc);
        apb(1'b0, IDX_OFFSET, 32'h0000_0000);
        check("offset", 32'h0000_000F, rd);
        apb(1'b0, IDX_TRIGGER, 32'h0000_0000);
        check("trigger clear", 32'h0000_0000, rd);
    endtask
    task automatic extRates();
        for (int r = 0; r < 4; r++) begin
            runOnce(cfgw(1, 1, 1, r % 2, r, 0, 1), 12'h100 + 12'(r));
            checkRange("ext0 time", int'(tk[r]) * 16 + 1, int'(tk[r]) * 16 + 9, cyc);
            check("span double", 32'(r % 2 == 0), 32'(span));
            apb(1'b0, IDX_EXT0, 32'h0000_0000);
            check("ext0", 32'h0000_00F1 + 32'(r), rd);
        end
    endtask
    task automatic boundCases();
        runOnce(cfgw(3, 3, 1, 0, 0, 1, 1), 12'hABC);
        apb(1'b0, IDX_TEMP, 32'h0000_0000);
        check("temp", 32'h0000_0ABC, rd);
        runOnce(cfgw(3, 1, 1, 0, 0, 1, 1), 12'h456);
        checkRange("reversed time", 481, 489, cyc);
        apb(1'b0, IDX_EXT0, 32'h0000_0000);
        check("ext0 untouched", 32'h0000_00F4, rd);
        runOnce(cfgw(2, 2, 1, 0, 3, 1, 0), 12'h555);
        checkRange("ext1 time", 321, 329, cyc);
        apb(1'b0, IDX_EXT1, 32'h0000_0000);
        check("ext1 disabled", 32'h0000_0000, rd);
    endtask
    task automatic continuousRun();
        logic [3:0] seen [$];
        int         n;
        apb(1'b1, IDX_CONFIG, cfgw(1, 2, 0, 0, 3, 1, 1));
        apb(1'b1, IDX_TRIGGER, 32'h0000_0001);
        n = 0;
        while (seen.size() < 3 && n < 3000) begin
            @(negedge mclk);
            n++;
            if (convActive === 1'b1 && (seen.size() == 0 ? convSlot === SLOT_EXT0
                    : convSlot !== seen[$]))
                seen.push_back(convSlot);
        end
        check("loop order", 32'h0000_0121, 32'({seen[0], seen[1], seen[2]}));
        apb(1'b0, IDX_TRIGGER, 32'h0000_0000);
        check("trigger kept", 32'h0000_0001, rd);
        apb(1'b1, IDX_TRIGGER, 32'h0000_0000);
        check("still busy", 32'h0000_0001, 32'(convActive));
        n = 0;
        while (convActive === 1'b1 && n < 1000) begin
            @(negedge mclk);
            n++;
        end
        checkRange("stop delay", 290, 330, n);
    endtask
    task automatic summarize();
        if (nErrors == 0 && checkCount > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // Hang guard, far beyond the roughly seven thousand cycles needed
    initial begin
        repeat (40000) @(posedge mclk);
        nErrors++;
        summarize();
    end
    initial begin
        repeat (20) @(posedge mclk);
        rst_n <= 1'b1;
        resetCheck();
        offsetCal();
        extRates();
        boundCases();
        continuousRun();
        summarize();
    end
endmodule
